// File: rtl/dpi_top.sv
// Door position indicator: debounced limit switches to a bicolour LED pair,
// plus a debounced pushbutton driving a time-limited control output.
// Assumes all three inputs are asynchronous pins with external pull-ups.
`timescale 1ns/1ps
`include "dpi_consts.svh"

// What this block does
// - Open low and shut high drives the pair to light red.
// - Shut low and open high drives the pair to light green.
// - Both inputs equal makes the pair swap colours repeatedly.
// - The two LED lines always sit at opposite levels.
// - Position inputs change only after holding stable for half a second.
// - Power-up shows red, green, then flashing, each for half a second.
// - Button low, debounced for 25 ms, raises the control output.
// - Control output stays high only while the button stays pressed.
// - Button held 500 ms is a fault; control output is forced low.
// - LED levels freeze while the button is judged pressed, once the power-up display has ended.
// - Power-on reset is generated internally; no external reset needed.
module dpi_top
  import dpi_pkg::*;
#(
  parameter int unsigned POS_DB_CYC = `DPI_POS_DB_MS * (`DPI_CLK_HZ / 1000),
  parameter int unsigned BTN_DB_CYC = `DPI_BTN_DB_MS * (`DPI_CLK_HZ / 1000),
  parameter int unsigned MAX_ON_CYC = `DPI_MAX_ON_MS * (`DPI_CLK_HZ / 1000),
  parameter int unsigned PHASE_CYC  = `DPI_PHASE_MS  * (`DPI_CLK_HZ / 1000),
  parameter int unsigned FLASH_CYC  = `DPI_FLASH_MS  * (`DPI_CLK_HZ / 1000)
) (
  // Clock and optional reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pins from switches and button
  input  wire logic open_limit_in,
  input  wire logic shut_limit_in,
  input  wire logic button_in,
  // Pins to the LED pair and the opener
  output logic      red_drive_line,
  output logic      green_drive_line,
  output logic      control_out
);

  // ---------------------------------------------------------------
  // Power-on reset
  // ---------------------------------------------------------------
  logic [4:0]  por_cnt_q = 5'h00;
  logic        por_done;
  logic        rst;

  // Power-up value of the counter holds the block in reset for a few cycles
  always_ff @(posedge ref_clk) begin
    if (!por_done) begin
      por_cnt_q <= por_cnt_q + 5'h01;
    end
  end
  assign por_done = (por_cnt_q == `DPI_POR_CYC);
  assign rst      = reset | !por_done;

  // All checks share this clock; all but por_hold_a are disabled by the combined internal and external reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Synchronisers and debouncers
  // ---------------------------------------------------------------
  logic [2:0]  raw_in;
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  stable_q;
  logic [31:0] db_cnt_q [3];

  // Index 0 open, 1 shut, 2 button
  assign raw_in = {button_in, shut_limit_in, open_limit_in};

  // Two flops per pin; pull-ups mean idle reads as high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= `DPI_SYNC_RST;
      sync2_q <= `DPI_SYNC_RST;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // A new level is accepted only after it holds for the full interval
  for (genvar g = 0; g < 3; g++) begin : g_db
    localparam int unsigned DB = (g == 2) ? BTN_DB_CYC : POS_DB_CYC;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        stable_q[g] <= 1'b1;
        db_cnt_q[g] <= 32'h0;
      end else if (sync2_q[g] == stable_q[g]) begin
        db_cnt_q[g] <= 32'h0; // Any bounce restarts the wait
      end else if (db_cnt_q[g] == DB - 1) begin
        stable_q[g] <= sync2_q[g];
        db_cnt_q[g] <= 32'h0;
      end else begin
        db_cnt_q[g] <= db_cnt_q[g] + 32'h1;
      end
    end
  end

  logic open_db;
  logic shut_db;
  logic pressed;
  assign open_db = stable_q[0];
  assign shut_db = stable_q[1];
  assign pressed = !stable_q[2];

  // A switch level may only be accepted at the end of a full count
  pos_debounce_a: assert property ($changed(stable_q[1:0]) |->
                                   ($past(db_cnt_q[0]) == POS_DB_CYC - 1) || ($past(db_cnt_q[1]) == POS_DB_CYC - 1))
    else $error("position accepted before debounce interval");

  // ---------------------------------------------------------------
  // Flash divider and power-up sequencer
  // ---------------------------------------------------------------
  logic [31:0] flash_cnt_q;
  logic        flash_q;
  logic [31:0] ph_cnt_q;
  dpi_phase_e  phase_q;

  // Free-running swap enable; shared by power-up and moving-door flashing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_cnt_q <= 32'h0;
      flash_q     <= 1'b1;
    end else if (flash_cnt_q == FLASH_CYC - 1) begin
      flash_cnt_q <= 32'h0;
      flash_q     <= !flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end

  // Swaps happen only when the divider wraps
  flash_rate_a:   assert property ($changed(flash_q) |-> $past(flash_cnt_q) == FLASH_CYC - 1)
    else $error("flash swap rate wrong");

  // Red, green, flashing, each one phase long, then normal display
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q  <= PH_RED;
      ph_cnt_q <= 32'h0;
    end else if (phase_q != PH_RUN) begin
      if (ph_cnt_q == PHASE_CYC - 1) begin
        ph_cnt_q <= 32'h0;
        case (phase_q)
          PH_RED:   phase_q <= PH_GREEN;
          PH_GREEN: phase_q <= PH_ALT;
          default:  phase_q <= PH_RUN;
        endcase
      end else begin
        ph_cnt_q <= ph_cnt_q + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // LED drive
  // ---------------------------------------------------------------
  dpi_led_s led_q;
  dpi_led_s flash_led;
  assign flash_led = flash_q ? DPI_RED : DPI_GREEN;

  // Pair is always complementary, so a swap is a colour change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      led_q <= DPI_RED;
    end else begin
      case (phase_q)
        PH_RED:   led_q <= DPI_RED;
        PH_GREEN: led_q <= DPI_GREEN;
        PH_ALT:   led_q <= flash_led;
        default: begin
          if (pressed) begin
            led_q <= led_q;
          end else if (!open_db && shut_db) begin
            led_q <= DPI_RED;
          end else if (!shut_db && open_db) begin
            led_q <= DPI_GREEN;
          end else begin
            led_q <= flash_led;
          end
        end
      endcase
    end
  end

  assign red_drive_line   = led_q.red;
  assign green_drive_line = led_q.green;

  // Colour selection checks apply in the run phase with the button up
  logic run_idle;
  assign run_idle = (phase_q == PH_RUN) && !pressed;

  sequence s_red_end;
    (phase_q == PH_RED) && (ph_cnt_q == PHASE_CYC - 1);
  endsequence
  sequence s_green_end;
    (phase_q == PH_GREEN) && (ph_cnt_q == PHASE_CYC - 1);
  endsequence

  red_select_a:   assert property (run_idle && !open_db && shut_db |=> led_q == DPI_RED)
    else $error("red not shown for open door");
  green_select_a: assert property (run_idle && !shut_db && open_db |=> led_q == DPI_GREEN)
    else $error("green not shown for shut door");
  flash_select_a: assert property (run_idle && (open_db == shut_db)
                                   |=> led_q.red == $past(flash_q))
    else $error("flash not shown for moving door");
  led_opposite_a: assert property (led_q.red != led_q.green)
    else $error("LED lines not complementary");
  led_freeze_a:   assert property ((phase_q == PH_RUN) && pressed |=> $stable(led_q))
    else $error("LED changed while pressed");
  powerup_seq_a:  assert property (s_red_end |=> (phase_q == PH_GREEN) && (led_q == DPI_RED)
                                   ##1 (led_q == DPI_GREEN))
    else $error("power-up red phase wrong");
  powerup_alt_a:  assert property (s_green_end |=> phase_q == PH_ALT)
    else $error("power-up green phase wrong");

  // ---------------------------------------------------------------
  // Control output with stuck-button limiter
  // ---------------------------------------------------------------
  logic        control_q;
  logic        lock_q;
  logic [31:0] on_cnt_q;

  // Follows the button up to the limit; lock needs a release to clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_q <= 1'b0;
      lock_q    <= 1'b0;
      on_cnt_q  <= 32'h0;
    end else if (!pressed) begin
      control_q <= 1'b0;
      lock_q    <= 1'b0;
      on_cnt_q  <= 32'h0;
    end else if (lock_q) begin
      control_q <= 1'b0;
    end else if (!control_q) begin
      control_q <= 1'b1;
      on_cnt_q  <= 32'h0;
    end else if (on_cnt_q == MAX_ON_CYC - 1) begin
      control_q <= 1'b0;
      lock_q    <= 1'b1;
    end else begin
      on_cnt_q  <= on_cnt_q + 32'h1;
    end
  end

  assign control_out = control_q;

  // Control follows the debounced button, with the stuck-button cut and lock
  button_on_a:    assert property ($fell(stable_q[2]) |=> control_q)
    else $error("control not raised on press");
  button_off_a:   assert property (!pressed |=> !control_q)
    else $error("control high without press");
  stuck_cut_a:    assert property (control_q && (on_cnt_q == MAX_ON_CYC - 1) && pressed
                                   |=> !control_q && lock_q)
    else $error("stuck button not cut off");
  relock_a:       assert property (lock_q && pressed |=> !control_q)
    else $error("control re-raised without release");

  // Reset itself is under test here, so this check is never disabled
  por_hold_a:     assert property (disable iff (1'b0)
                                   !por_done |=> !control_q && (phase_q == PH_RED))
    else $error("internal reset not applied");

endmodule : dpi_top

// File: rtl/dpi_consts.svh
// Timing constants for the door position indicator.
// Assumes a single 100 MHz clock; counts are derived in the top module.
`ifndef DPI_CONSTS_SVH
`define DPI_CONSTS_SVH

`define DPI_CLK_HZ     100000000
`define DPI_POS_DB_MS  500
`define DPI_BTN_DB_MS  25
`define DPI_MAX_ON_MS  500
`define DPI_PHASE_MS   500
`define DPI_FLASH_MS   125
`define DPI_POR_CYC    5'h10
`define DPI_SYNC_RST   3'h7

`endif

// File: rtl/dpi_pkg.sv
// Types shared by the door position indicator.
// Assumes nothing beyond a SystemVerilog compiler.
package dpi_pkg;

  // Power-up display phases, then normal running
  typedef enum logic [1:0] {PH_RED, PH_GREEN, PH_ALT, PH_RUN} dpi_phase_e;

  // Complementary drive pair for the bicolour indicator
  typedef struct packed {
    logic red;
    logic green;
  } dpi_led_s;

  localparam dpi_led_s DPI_RED   = '{red: 1'b1, green: 1'b0};
  localparam dpi_led_s DPI_GREEN = '{red: 1'b0, green: 1'b1};

endpackage : dpi_pkg

// File: testbench/dpi_field_model.sv
// Field model: two reed switches, a pushbutton and a bicolour LED pair.
// Assumes the bench commands door state and press; pins move on falling edges.
`timescale 1ns/1ps
module dpi_field_model (
  // Clock and bench commands
  input  wire logic       ref_clk,
  input  wire logic [1:0] door,
  input  wire logic       press,
  // Pins towards the block
  output logic            open_limit_in,
  output logic            shut_limit_in,
  output logic            button_in,
  // LED pair and the colour it shows
  input  wire logic       red_drive_line,
  input  wire logic       green_drive_line,
  output logic [1:0]      lit
);
  // ----------------------------------------
  // Switch and button pins
  // ----------------------------------------
  // Pull-ups hold a pin high unless its contact closes; door: 0 open, 1 shut, 2 moving, 3 both closed
  // Pins follow the commands directly, so they move on the bench's falling edge without a race
  assign open_limit_in = !(door == 2'h0 || door == 2'h3);
  assign shut_limit_in = !(door == 2'h1 || door == 2'h3);
  assign button_in     = !press;

  // Colour seen: bit 0 red, bit 1 green; equal levels leave the pair dark
  assign lit = {green_drive_line & ~red_drive_line, red_drive_line & ~green_drive_line};
endmodule : dpi_field_model

// File: testbench/test_door_position_indicator.sv
// Self-checking bench for the door position indicator.
// Assumes shortened counts: position 20, button 5, max-on 50, phase 30, flash 8.
`timescale 1ns/1ps
module test_door_position_indicator;
  logic       ref_clk = 1'b0;
  logic       reset   = 1'b1;
  logic [1:0] door    = 2'h2;
  logic       press   = 1'b0;
  logic       open_limit_in, shut_limit_in, button_in;
  logic       red_drive_line, green_drive_line, control_out;
  logic [1:0] lit;
  int         err_count = 0;
  int         checks    = 0;

  // ----------------------------------------
  // Clock, design and field
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;

  dpi_top #(.POS_DB_CYC(20), .BTN_DB_CYC(5), .MAX_ON_CYC(50), .PHASE_CYC(30), .FLASH_CYC(8)) dut (
    .ref_clk(ref_clk), .reset(reset), .open_limit_in(open_limit_in), .shut_limit_in(shut_limit_in),
    .button_in(button_in), .red_drive_line(red_drive_line), .green_drive_line(green_drive_line),
    .control_out(control_out));

  dpi_field_model field (
    .ref_clk(ref_clk), .door(door), .press(press), .open_limit_in(open_limit_in),
    .shut_limit_in(shut_limit_in), .button_in(button_in), .red_drive_line(red_drive_line),
    .green_drive_line(green_drive_line), .lit(lit));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic chk(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk

  // Counts colour swaps over n cycles and checks the pair stays opposite
  task automatic swaps(input int n, output int s);
    logic last;
    s = 0;
    last = red_drive_line;
    repeat (n) begin
      cyc(1);
      chk("pair_opposite", 1'b1, red_drive_line ^ green_drive_line);
      if (red_drive_line !== last) s++;
      last = red_drive_line;
    end
  endtask : swaps

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Red, green, then flashing, each for one phase after reset
  task automatic t_powerup;
    int s;
    cyc(15);
    chk("pwr_red", 1'b1, lit[0]);
    cyc(30);
    chk("pwr_green", 1'b1, lit[1]);
    cyc(17);
    swaps(24, s);
    chk("pwr_flash", 1'b1, s >= 2);
    $display("test powerup done");
  endtask : t_powerup

  // Open shows red; short glitches are ignored, long changes accepted
  task automatic t_position;
    door = 2'h0;
    cyc(30);
    chk("open_red", 1'b1, lit[0]);
    door = 2'h1;
    cyc(10);
    chk("debounce_hold", 1'b1, lit[0]);
    cyc(20);
    chk("shut_green", 1'b1, lit[1]);
    door = 2'h0;
    cyc(10);
    door = 2'h1;
    cyc(30);
    chk("glitch_ignored", 1'b1, lit[1]);
    $display("test position done");
  endtask : t_position

  // Both reeds open or both closed flash at one swap per 8 cycles
  task automatic t_flash;
    int s;
    for (int d = 2; d < 4; d++) begin
      door = 2'(d);
      cyc(30);
      swaps(64, s);
      chk("flash_rate", 1'b1, s >= 7 && s <= 9);
    end
    $display("test flash done");
  endtask : t_flash

  // LED pair freezes while the button is held
  task automatic t_freeze;
    door = 2'h1;
    cyc(30);
    press = 1'b1;
    cyc(12);
    door = 2'h0;
    cyc(40);
    chk("freeze_green", 1'b1, lit[1]);
    press = 1'b0;
    cyc(35);
    chk("thaw_red", 1'b1, lit[0]);
    $display("test freeze done");
  endtask : t_freeze

  // Debounced press, follow on release, stuck timeout and relock
  task automatic t_button;
    press = 1'b1;
    cyc(5);
    chk("ctl_debounce", 1'b0, control_out);
    cyc(7);
    chk("ctl_high", 1'b1, control_out);
    press = 1'b0;
    cyc(12);
    chk("ctl_release", 1'b0, control_out);
    press = 1'b1;
    cyc(32);
    chk("ctl_held", 1'b1, control_out);
    cyc(30);
    chk("ctl_stuck", 1'b0, control_out);
    cyc(20);
    chk("ctl_locked", 1'b0, control_out);
    press = 1'b0;
    cyc(12);
    press = 1'b1;
    cyc(12);
    chk("ctl_repress", 1'b1, control_out);
    press = 1'b0;
    cyc(12);
    chk("ctl_off", 1'b0, control_out);
    $display("test button done");
  endtask : t_button

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset_red", 1'b1, lit[0]);
    reset = 1'b0;
    t_powerup();
    t_position();
    t_flash();
    t_freeze();
    t_button();
    end_sim();
  end

  // Tests take about 650 cycles; over seven times that means a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim();
  end
endmodule : test_door_position_indicator
